// ==== mlh_pkg.sv ====
/*
  mechanical limit homing package: object indices, status bit positions,
  method codes, state encoding and the drive command carrier.
  assumes: included before mlh_homing; no timescale of its own.
*/
`default_nettype none
package mlh_pkg;
  // object indices on the object access port
  localparam logic [15:0] OBJ_CUR_THR      = 16'h207B;
  localparam logic [15:0] OBJ_CUR_THR_TIME = 16'h207C;
  localparam logic [15:0] OBJ_HOME_OFFSET  = 16'h607C;
  localparam logic [15:0] OBJ_METHOD       = 16'h6098;
  localparam logic [15:0] OBJ_CTRL_WORD    = 16'h6040;
  localparam logic [15:0] OBJ_STATUS_WORD  = 16'h6041;
  // reset values
  localparam logic [31:0] RST_WORD32  = 32'h0000_0000;
  localparam logic [7:0]  RST_METHOD  = 8'h00;
  localparam logic [15:0] RST_CTRL    = 16'h0000;
  // control and status field positions
  localparam int CTRL_START_BIT  = 4;
  localparam int CTRL_HALT_BIT   = 8;
  localparam int STAT_TARGET_BIT = 10;
  localparam int STAT_ATTAIN_BIT = 12;
  localparam int STAT_ERROR_BIT  = 13;
  // signed method numbers as raw bytes
  localparam logic [7:0] METH_NEG_INDEX = 8'hFF;
  localparam logic [7:0] METH_POS_INDEX = 8'hFE;
  localparam logic [7:0] METH_NEG_DIST  = 8'hFD;
  localparam logic [7:0] METH_POS_DIST  = 8'hFC;
  localparam logic [7:0] METH_NONE      = 8'h00;
  // timing: threshold time object counts ticks of this length
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SEEK = 5'h02,
    ST_REV  = 5'h04,
    ST_DONE = 5'h08,
    ST_ERR  = 5'h10
  } mlh_state_type;

  // motion command towards the position loop
  typedef struct packed {
    logic        move_en;   // motion requested
    logic        move_dir;  // 1 positive, 0 negative
    logic        pos_load;  // one-cycle load of reported position
    logic [31:0] pos_value; // value to load
  } mlh_cmd_type;
endpackage : mlh_pkg
`default_nettype wire

// ==== mlh_homing.sv ====
/*
  mechanical limit homing sequencer: methods -1 to -4 with current
  threshold and control-error detection, object access port, status word.
  assumes: all inputs synchronous to ref_clk; pos_step pulses once per
  position unit travelled; the position loop obeys the command struct.
*/
// Function
// - current variant only for closed loop motors
// - control-error variant only open loop with encoder
// - current above threshold for time, then reverse
// - method -1 seeks negative, homes next index
// - method -2 seeks positive, homes next index
// - negative control error marks limit, reverse
// - positive control error marks limit, reverse
// - control error uses protection, not homing threshold
// - method -3 stops after home offset travel
// - method -4 stops after absolute offset travel
// - control-error limit position is home reference
// - at end load position with home offset
// - success sets attained and target reached
`timescale 1ns/1ps
`default_nettype none
module mlh_homing
  import mlh_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  // object access port
  input  wire logic                 obj_req,
  input  wire logic                 obj_we,
  input  wire logic [15:0]          obj_index,
  input  wire logic [31:0]          obj_wdata,
  output var  logic [31:0]          obj_rdata_q,
  output var  logic                 obj_ack_q,
  output var  logic                 obj_err_q,
  // drive configuration and feedback
  input  wire logic                 cfg_closed_loop,
  input  wire logic                 cfg_has_encoder,
  input  wire logic [31:0]          motor_current,
  input  wire logic                 ctrl_err,
  input  wire logic                 index_pulse,
  input  wire logic                 pos_step,
  // motion command and status
  output var  mlh_pkg::mlh_cmd_type cmd_q,
  output var  logic [15:0]          status_word_q
);
  import mlh_pkg::*;

  logic [31:0]   cur_thr_q;
  logic [31:0]   cur_time_q;
  logic [31:0]   offset_q;
  logic [7:0]    method_q;
  logic [15:0]   ctrl_q;
  logic          start_q;
  logic          use_cur_q;
  mlh_state_type state_q;
  mlh_state_type state_d;
  logic [7:0]    tick_q;
  logic [31:0]   cur_cnt_q;
  logic [31:0]   dist_q;
  logic          cur_hit;
  logic          limit_hit;
  logic          seek_pos;
  logic          idx_method;
  logic          meth_ok;
  logic          halt;

  // magnitude of a signed 32-bit distance
  function automatic logic [31:0] abs32(input logic [31:0] v);
    abs32 = v[31] ? 32'(-v) : v;
  endfunction : abs32

  assign seek_pos   = ~method_q[0];
  assign idx_method = (method_q == METH_NEG_INDEX) || (method_q == METH_POS_INDEX);
  assign meth_ok    = idx_method || (method_q == METH_NEG_DIST) || (method_q == METH_POS_DIST);
  assign halt       = ctrl_q[CTRL_HALT_BIT];

  // object writes; start is the rising edge of the start bit
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cur_thr_q  <= RST_WORD32;
      cur_time_q <= RST_WORD32;
      offset_q   <= RST_WORD32;
      method_q   <= RST_METHOD;
      ctrl_q     <= RST_CTRL;
      start_q    <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      if (obj_req && obj_we)
      begin
        if (obj_index == OBJ_CUR_THR)
          cur_thr_q <= obj_wdata;
        else if (obj_index == OBJ_CUR_THR_TIME)
          cur_time_q <= obj_wdata;
        else if (obj_index == OBJ_HOME_OFFSET)
          offset_q <= obj_wdata;
        // method latched from the master's write
        else if (obj_index == OBJ_METHOD)
          method_q <= obj_wdata[7:0];
        else if (obj_index == OBJ_CTRL_WORD)
        begin
          ctrl_q  <= obj_wdata[15:0];
          start_q <= obj_wdata[CTRL_START_BIT] && !ctrl_q[CTRL_START_BIT];
        end
      end
    end
  end

  // object reads answer one cycle after the request
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      obj_rdata_q <= RST_WORD32;
      obj_ack_q   <= 1'b0;
      obj_err_q   <= 1'b0;
    end
    else
    begin
      obj_ack_q   <= obj_req;
      obj_err_q   <= 1'b0;
      obj_rdata_q <= RST_WORD32;
      if (obj_req)
      begin
        if (obj_index == OBJ_CUR_THR)
          obj_rdata_q <= cur_thr_q;
        else if (obj_index == OBJ_CUR_THR_TIME)
          obj_rdata_q <= cur_time_q;
        else if (obj_index == OBJ_HOME_OFFSET)
          obj_rdata_q <= offset_q;
        else if (obj_index == OBJ_METHOD)
          obj_rdata_q <= {{24{method_q[7]}}, method_q};
        else if (obj_index == OBJ_CTRL_WORD)
          obj_rdata_q <= {16'h0000, ctrl_q};
        else if (obj_index == OBJ_STATUS_WORD)
          obj_err_q <= obj_we; // status word is read-only
        else
          obj_err_q <= 1'b1;
        if (obj_index == OBJ_STATUS_WORD)
          obj_rdata_q <= {16'h0000, status_word_q};
      end
    end
  end

  // free-running prescaler for the threshold time base
  always_ff @(posedge ref_clk)
  begin
    if (srst || tick_q == TICK_LAST)
      tick_q <= 8'h00;
    else
      tick_q <= tick_q + 8'h01;
  end

  // current dwell counter, cleared whenever current drops below
  always_ff @(posedge ref_clk)
  begin
    if (srst || state_q != ST_SEEK || motor_current <= cur_thr_q)
      cur_cnt_q <= RST_WORD32;
    else if (tick_q == TICK_LAST && cur_cnt_q != 32'hFFFF_FFFF)
      cur_cnt_q <= cur_cnt_q + 32'h0000_0001;
  end

  // current above threshold for the threshold time
  assign cur_hit = (motor_current > cur_thr_q) && (cur_cnt_q >= cur_time_q);
  // control error comes from the drive's own protection
  assign limit_hit = use_cur_q ? cur_hit : ctrl_err;

  // travel counted from the limit; the limit is the reference point
  always_ff @(posedge ref_clk)
  begin
    if (srst || state_q != ST_REV)
      dist_q <= RST_WORD32;
    // distance measured from the control-error position
    else if (pos_step)
      dist_q <= dist_q + 32'h0000_0001;
  end

  // variant chosen at start from the motor configuration
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      use_cur_q <= 1'b0;
    // current variant for closed loop only
    else if (start_q && state_q != ST_SEEK && state_q != ST_REV)
      use_cur_q <= cfg_closed_loop;
  end

  // sequencer next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE, ST_DONE, ST_ERR:
      begin
        if (start_q && !halt)
        begin
          // open loop needs an encoder for the error variant
          if (!meth_ok || (!cfg_closed_loop && !cfg_has_encoder))
            state_d = ST_ERR;
          else
            state_d = ST_SEEK;
        end
      end
      ST_SEEK:
      begin
        if (halt)
          state_d = ST_IDLE;
        // negative seek ends on limit detection
        // positive seek ends on limit detection
        else if (limit_hit)
          state_d = ST_REV;
      end
      ST_REV:
      begin
        if (halt)
          state_d = ST_IDLE;
        // index after reversing from the negative stop
        // index after reversing from the positive stop
        else if (idx_method && index_pulse)
          state_d = ST_DONE;
        // stop once the offset has been travelled
        // absolute offset for both distance methods
        else if (!idx_method && dist_q >= abs32(offset_q))
          state_d = ST_DONE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // motion command registered from the next state
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      cmd_q <= '0;
    else
    begin
      cmd_q.move_en  <= (state_d == ST_SEEK) || (state_d == ST_REV);
      cmd_q.move_dir <= (state_d == ST_REV) ? !seek_pos : seek_pos;
      // position takes the home offset at completion
      cmd_q.pos_load  <= (state_d == ST_DONE) && (state_q == ST_REV);
      cmd_q.pos_value <= offset_q;
    end
  end

  // status word; halted or never started reads as interrupted
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      status_word_q <= 16'h0400;
    else
    begin
      status_word_q <= 16'h0000;
      // success shows attained and target reached
      status_word_q[STAT_ATTAIN_BIT] <= (state_d == ST_DONE);
      status_word_q[STAT_TARGET_BIT] <= (state_d != ST_SEEK) && (state_d != ST_REV);
      status_word_q[STAT_ERROR_BIT]  <= (state_d == ST_ERR);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_cur_closed_only: assert property ($rose(state_q == ST_SEEK) |-> use_cur_q == cfg_closed_loop)
    else $error("current variant chosen for wrong configuration");
  a_err_needs_encoder: assert property ($rose(state_q == ST_SEEK) && !use_cur_q |-> $past(cfg_has_encoder))
    else $error("control-error variant without encoder");
  a_cur_dwell_reverse: assert property (state_q == ST_SEEK && use_cur_q && cur_hit && !halt |=> state_q == ST_REV)
    else $error("current dwell did not reverse");
  a_neg_seek_dir: assert property (state_q == ST_SEEK && method_q[0] |-> cmd_q.move_en && !cmd_q.move_dir)
    else $error("negative method not moving negative");
  a_pos_index_stop: assert property (state_q == ST_REV && method_q == METH_POS_INDEX && index_pulse && !halt |=> state_q == ST_DONE && !cmd_q.move_en)
    else $error("index did not end method -2");
  a_err_reverse: assert property (state_q == ST_SEEK && !use_cur_q && ctrl_err && !halt |=> state_q == ST_REV && cmd_q.move_dir == method_q[0])
    else $error("control error did not reverse");
  a_dist_stop: assert property (state_q == ST_REV && !idx_method && !halt && dist_q >= abs32(offset_q) |=> state_q == ST_DONE)
    else $error("offset travel did not stop");
  a_offset_load: assert property ($rose(state_q == ST_DONE) |-> cmd_q.pos_load && cmd_q.pos_value == offset_q)
    else $error("position not loaded with offset");
  a_success_status: assert property (state_q == ST_DONE |-> status_word_q[STAT_ATTAIN_BIT] && status_word_q[STAT_TARGET_BIT] && !status_word_q[STAT_ERROR_BIT])
    else $error("success status bits wrong");

  c_index_home: cover property (state_q == ST_REV && idx_method ##1 state_q == ST_DONE);
  c_dist_home: cover property (state_q == ST_REV && !idx_method ##1 state_q == ST_DONE);
  c_err_variant: cover property (state_q == ST_SEEK && !use_cur_q ##1 state_q == ST_REV);
  c_halted: cover property (state_q == ST_SEEK ##1 state_q == ST_IDLE);
endmodule : mlh_homing
`default_nettype wire

// ==== mlh_mech.sv ====
/*
  axis model behind the homing block: one unit every four cycles,
  hard stops at +-LIM, index pulse every eight units.
  assumes: driven by the command struct of mlh_homing on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mlh_mech
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  // command in
  input  wire mlh_pkg::mlh_cmd_type cmd,
  input  wire logic                 closed_loop,
  // feedback out
  output var  logic [31:0]          motor_current,
  output var  logic                 ctrl_err,
  output var  logic                 index_pulse,
  output var  logic                 pos_step
);
  import mlh_pkg::*;
  localparam int LIM = 20;
  int         pos_q;
  logic [1:0] div_q;
  logic       stop;
  logic       stp;
  // pushing into a stop: current rises or the control error trips
  assign stop = cmd.move_en && (cmd.move_dir ? pos_q >= LIM : pos_q <= -LIM);
  assign stp = cmd.move_en && !stop && div_q == 2'h3;
  assign motor_current = (stop && closed_loop) ? 32'h0000_0100 : 32'h0000_0010;
  assign ctrl_err = stop && !closed_loop;
  // slow stepping keeps a stray unit out of the stop decision
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pos_q <= 0;
      div_q <= 2'h0;
      pos_step <= 1'b0;
      index_pulse <= 1'b0;
    end
    else
    begin
      div_q <= cmd.move_en ? div_q + 2'h1 : 2'h0;
      pos_step <= stp;
      index_pulse <= stp && (pos_q % 8 == 0);
      if (stp)
        pos_q <= cmd.move_dir ? pos_q + 1 : pos_q - 1;
    end
  end
endmodule : mlh_mech
`default_nettype wire

// ==== testbench.sv ====
/*
  testbench for the homing block: object accesses and homing runs.
  assumes: mlh_pkg compiled first, mlh_mech as the axis.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mlh_pkg::*;
  logic ref_clk, srst, obj_req, obj_we, obj_ack_q, obj_err_q;
  logic [15:0] obj_index, status_word_q;
  logic [31:0] obj_wdata, obj_rdata_q, motor_current, rdv;
  logic cfg_closed_loop, cfg_has_encoder, ctrl_err, index_pulse, pos_step, erv;
  mlh_cmd_type cmd_q;
  int num_errors = 0;
  int samples_checked = 0;

  mlh_homing dut_u (.ref_clk(ref_clk), .srst(srst), .obj_req(obj_req), .obj_we(obj_we),
    .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata_q(obj_rdata_q),
    .obj_ack_q(obj_ack_q), .obj_err_q(obj_err_q), .cfg_closed_loop(cfg_closed_loop),
    .cfg_has_encoder(cfg_has_encoder), .motor_current(motor_current), .ctrl_err(ctrl_err),
    .index_pulse(index_pulse), .pos_step(pos_step), .cmd_q(cmd_q),
    .status_word_q(status_word_q));
  mlh_mech mech_u (.ref_clk(ref_clk), .srst(srst), .cmd(cmd_q), .closed_loop(cfg_closed_loop),
    .motor_current(motor_current), .ctrl_err(ctrl_err), .index_pulse(index_pulse),
    .pos_step(pos_step));

  // 25 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic results;
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // one access; answer taken at the edge after the taking edge
  task automatic acc(input logic we, input logic [15:0] ix, input logic [31:0] wd,
                     input logic ex);
    @(posedge ref_clk);
    obj_req <= 1'b1;
    obj_we <= we;
    obj_index <= ix;
    obj_wdata <= wd;
    @(posedge ref_clk);
    obj_req <= 1'b0;
    @(posedge ref_clk);
    rdv = obj_rdata_q;
    erv = obj_err_q;
    chk("ack", 32'h1, {31'h0, obj_ack_q});
    chk("err", {31'h0, ex}, {31'h0, erv});
  endtask : acc

  task automatic rdc(input logic [15:0] ix, input logic [31:0] exp);
    acc(1'b0, ix, 32'h0, 1'b0);
    chk("rdata", exp, rdv);
  endtask : rdc

  // configure, start, then follow the run to its end
  task automatic home(input logic [7:0] m, input logic [31:0] off, input logic cl,
                      input logic en, input logic dir, input logic [15:0] st, input int trav);
    int steps;
    logic seen;
    steps = 0;
    seen = 1'b0;
    cfg_closed_loop <= cl;
    cfg_has_encoder <= en;
    acc(1'b1, OBJ_HOME_OFFSET, off, 1'b0);
    acc(1'b1, OBJ_METHOD, {24'h0, m}, 1'b0);
    acc(1'b1, OBJ_CTRL_WORD, 32'h0, 1'b0);
    acc(1'b1, OBJ_CTRL_WORD, 32'h10, 1'b0);
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i <= 3000; i++)
    begin
      @(posedge ref_clk);
      #1;
      if (cmd_q.move_en === 1'b1 && !seen)
      begin
        seen = 1'b1;
        chk("seek_dir", {31'h0, dir}, {31'h0, cmd_q.move_dir});
      end
      if (cmd_q.move_en === 1'b1 && cmd_q.move_dir === !dir && pos_step === 1'b1)
        steps++;
      if (status_word_q[13] !== 1'b0 || status_word_q[12] !== 1'b0)
        break;
      if (i == 3000)
      begin
        num_errors++;
        results();
      end
    end
    chk("status", {16'h0, st}, {16'h0, status_word_q});
    if (st == 16'h1400)
    begin
      chk("pos_load", 32'h1, {31'h0, cmd_q.pos_load});
      chk("pos_value", off, cmd_q.pos_value);
      chk("travel", trav, steps);
    end
  endtask : home

  initial
  begin
    srst = 1'b1;
    obj_req = 1'b0;
    obj_we = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 32'h0000_0000;
    cfg_closed_loop = 1'b1;
    cfg_has_encoder = 1'b0;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    // reset values, read back, refused accesses
    rdc(OBJ_CUR_THR, 32'h0);
    rdc(OBJ_HOME_OFFSET, 32'h0);
    rdc(OBJ_METHOD, 32'h0);
    rdc(OBJ_STATUS_WORD, 32'h0000_0400);
    acc(1'b1, OBJ_CUR_THR, 32'h0000_0080, 1'b0);
    acc(1'b1, OBJ_CUR_THR_TIME, 32'h0000_0001, 1'b0);
    acc(1'b1, OBJ_METHOD, 32'h0000_00FC, 1'b0);
    rdc(OBJ_CUR_THR, 32'h0000_0080);
    rdc(OBJ_CUR_THR_TIME, 32'h0000_0001);
    rdc(OBJ_METHOD, 32'hFFFF_FFFC);
    acc(1'b0, 16'h1234, 32'h0, 1'b1);
    acc(1'b1, OBJ_STATUS_WORD, 32'h0, 1'b1);
    // current variant, all four methods, axis continues between runs
    home(METH_NEG_INDEX, 32'h0000_0007, 1'b1, 1'b0, 1'b0, 16'h1400, 5);
    home(METH_POS_INDEX, 32'h0000_0003, 1'b1, 1'b0, 1'b1, 16'h1400, 5);
    home(METH_NEG_DIST, 32'h0000_0005, 1'b1, 1'b0, 1'b0, 16'h1400, 5);
    home(METH_POS_DIST, 32'hFFFF_FFFA, 1'b1, 1'b0, 1'b1, 16'h1400, 6);
    // control-error variant on open loop with encoder
    home(METH_NEG_INDEX, 32'h0000_0002, 1'b0, 1'b1, 1'b0, 16'h1400, 5);
    home(METH_POS_DIST, 32'hFFFF_FFFD, 1'b0, 1'b1, 1'b1, 16'h1400, 3);
    // halt in mid-seek: in progress first, then interrupted and still
    acc(1'b1, OBJ_METHOD, {24'h0, METH_NEG_DIST}, 1'b0);
    acc(1'b1, OBJ_CTRL_WORD, 32'h0, 1'b0);
    acc(1'b1, OBJ_CTRL_WORD, 32'h10, 1'b0);
    @(posedge ref_clk);
    chk("run_status", 32'h0, {16'h0, status_word_q});
    chk("run_move", 32'h1, {31'h0, cmd_q.move_en});
    chk("run_dir", 32'h0, {31'h0, cmd_q.move_dir});
    acc(1'b1, OBJ_CTRL_WORD, 32'h110, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk("halt_status", 32'h0000_0400, {16'h0, status_word_q});
    chk("halt_move", 32'h0, {31'h0, cmd_q.move_en});
    // refused: open loop without encoder, method outside -1..-4
    home(METH_NEG_DIST, 32'h0000_0004, 1'b0, 1'b0, 1'b0, 16'h2400, 0);
    home(8'h05, 32'h0000_0004, 1'b1, 1'b0, 1'b0, 16'h2400, 0);
    results();
  end
endmodule : testbench
`default_nettype wire
